// *** logic/byte_rotate.sv ***
// Execution datapath for the rotate-left and rotate-right-through-carry instructions.
`timescale 1ns/1ns
`default_nettype none
`include "rotate_defs.svh"
module byte_rotate
    import rotate_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic carry_i,
    input wire logic [7:0] mem_rdata_i,
    output logic busy_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [11:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic w_wr_o,
    output logic [7:0] w_data_o,
    output logic carry_wr_o,
    output logic carry_o,
    output logic neg_o,
    output logic zero_o,
    output logic done_o
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        phase_type phase;
        logic is_left;
        logic dest;
        logic [11:0] addr;
        logic cin;
        logic busy;
        logic mem_rd;
        logic mem_wr;
        logic [7:0] wdata;
        logic w_wr;
        logic [7:0] w_data;
        logic carry_wr;
        logic carry;
        logic neg;
        logic zero;
        logic done;
    } state_type;

    state_type state_r;
    state_type state_nxt;
    logic [11:0] res_addr;
    logic [5:0] opc;
    logic [7:0] rot;

    assign opc = instr_i[`OPC_HI:`OPC_LO];

    bank_resolve u_bank (
        .faddr_i(instr_i[`FADDR_HI:0]),
        .access_i(instr_i[`ACCESS_BIT]),
        .bank_select_register_i(bank_select_register_i),
        .addr_o(res_addr)
    );

    // ****************************************
    // Next state
    // ****************************************
    // Memory read data is taken one cycle after the read strobe.
    always_comb begin
        state_nxt = state_r;
        state_nxt.mem_rd = 1'b0;
        state_nxt.mem_wr = 1'b0;
        state_nxt.w_wr = 1'b0;
        state_nxt.carry_wr = 1'b0;
        state_nxt.done = 1'b0;
        rot = `BYTE_ZERO;
        case (state_r.phase)
            ST_IDLE: begin
                if (instr_valid_i && (opc == `OPC_ROT_LEFT || opc == `OPC_ROT_RIGHT)) begin
                    state_nxt.is_left = (opc == `OPC_ROT_LEFT);
                    state_nxt.dest = instr_i[`DEST_BIT];
                    state_nxt.addr = res_addr;
                    // The carry is captured at issue; a carry update still in flight from an
                    // older instruction is not seen, so the decoder must not overlap them.
                    state_nxt.cin = carry_i;
                    state_nxt.mem_rd = 1'b1;
                    state_nxt.busy = 1'b1;
                    state_nxt.phase = ST_READ;
                end
            end
            ST_READ: begin
                // Wait out the one-clock read latency of the data memory.
                state_nxt.phase = ST_WRITE;
            end
            ST_WRITE: begin
                if (state_r.is_left) begin
                    rot = {mem_rdata_i[6:0], mem_rdata_i[7]};
                end else begin
                    rot = {state_r.cin, mem_rdata_i[7:1]};
                    state_nxt.carry_wr = 1'b1;
                    state_nxt.carry = mem_rdata_i[0];
                end
                if (state_r.dest) begin
                    state_nxt.mem_wr = 1'b1;
                    state_nxt.wdata = rot;
                end else begin
                    state_nxt.w_wr = 1'b1;
                    state_nxt.w_data = rot;
                end
                // N and Z follow the rotated byte whichever destination takes it.
                state_nxt.neg = rot[7];
                state_nxt.zero = (rot == `BYTE_ZERO);
                state_nxt.done = 1'b1;
                state_nxt.busy = 1'b0;
                state_nxt.phase = ST_IDLE;
            end
            default: begin
                state_nxt.phase = ST_IDLE;
                state_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Every output is a field of the state register, so none has a combinational path.
    assign busy_o = state_r.busy;
    assign mem_rd_o = state_r.mem_rd;
    assign mem_wr_o = state_r.mem_wr;
    assign mem_addr_o = state_r.addr;
    assign mem_wdata_o = state_r.wdata;
    assign w_wr_o = state_r.w_wr;
    assign w_data_o = state_r.w_data;
    assign carry_wr_o = state_r.carry_wr;
    assign carry_o = state_r.carry;
    assign neg_o = state_r.neg;
    assign zero_o = state_r.zero;
    assign done_o = state_r.done;

    // ****************************************
    // Checks
    // ****************************************
    a_left_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && state_r.is_left && !state_r.dest) |=>
        (w_data_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}))
        else $error("left rotate result wrong");
    a_right_carry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && !state_r.is_left) |=>
        (carry_wr_o && carry_o == $past(mem_rdata_i[0])))
        else $error("right rotate carry wrong");
    a_right_msb: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && !state_r.is_left && state_r.dest) |=>
        (mem_wdata_o[7] == $past(state_r.cin)))
        else $error("carry not shifted into bit 7");
    a_dest_w: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && !state_r.dest) |=> (w_wr_o && !mem_wr_o))
        else $error("dest zero must write working register only");
    a_dest_file: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mem_rd_o && state_r.dest) |-> ##2 (mem_wr_o && !w_wr_o && $stable(mem_addr_o)))
        else $error("dest one must write back same address");
    // Addresses are checked one cycle after the issue edge against the raw instruction fields.
    a_access_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_IDLE && instr_valid_i && opc == `OPC_ROT_LEFT
         && !instr_i[`ACCESS_BIT] && instr_i[`FADDR_HI:0] < `ACCESS_SPLIT)
        |=> (mem_addr_o == {`BANK_ACCESS_LOW, $past(instr_i[`FADDR_HI:0])}))
        else $error("access bank address wrong");
    a_access_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_IDLE && instr_valid_i && opc == `OPC_ROT_RIGHT
         && !instr_i[`ACCESS_BIT] && instr_i[`FADDR_HI:0] >= `ACCESS_SPLIT)
        |=> (mem_addr_o == {`ACCESS_SFR_BANK, $past(instr_i[`FADDR_HI:0])}))
        else $error("upper access bank address wrong");
    a_access_banked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_IDLE && instr_valid_i
         && (opc == `OPC_ROT_LEFT || opc == `OPC_ROT_RIGHT) && instr_i[`ACCESS_BIT])
        |=> (mem_addr_o == {$past(bank_select_register_i), $past(instr_i[`FADDR_HI:0])}))
        else $error("banked address wrong");
    a_done_time: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        mem_rd_o |-> ##2 (done_o && !busy_o))
        else $error("rotate not done in three cycles");
    a_busy_span: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        mem_rd_o |-> (busy_o ##1 busy_o ##1 !busy_o))
        else $error("busy window wrong");
    a_left_file: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && state_r.is_left && state_r.dest) |=>
        (mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}))
        else $error("left rotate write-back data wrong");
    a_right_w: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && !state_r.is_left && !state_r.dest) |=>
        (w_data_o == {$past(state_r.cin), $past(mem_rdata_i[7:1])}))
        else $error("right rotate result wrong");
    a_left_nocarry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_WRITE && state_r.is_left) |=> !carry_wr_o)
        else $error("left rotate must not touch carry");
    // Only the two rotate opcodes may start a read; all else belongs to other units.
    a_ignore_other: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r.phase == ST_IDLE && !(instr_valid_i
         && (opc == `OPC_ROT_LEFT || opc == `OPC_ROT_RIGHT))) |=> !mem_rd_o)
        else $error("read started without a rotate");
    // Covers mark that each rotate reached each destination.
    c_left_w: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        done_o && w_wr_o && !carry_wr_o);
    c_right_file: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        done_o && mem_wr_o && carry_wr_o);
    c_zero: cover property (@(posedge clk_i) disable iff (!rst_b_i) done_o && zero_o);
    c_left_file: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        done_o && mem_wr_o && !carry_wr_o);
    c_right_w: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        done_o && w_wr_o && carry_wr_o);
endmodule
`default_nettype wire

// *** logic/rotate_defs.svh ***
// Constant definitions for the byte rotate execution block.
`ifndef ROTATE_DEFS_SVH
`define ROTATE_DEFS_SVH
`define OPC_ROT_LEFT 6'h11
`define OPC_ROT_RIGHT 6'h0c
`define OPC_HI 15
`define OPC_LO 10
`define DEST_BIT 9
`define ACCESS_BIT 8
`define FADDR_HI 7
`define ACCESS_SPLIT 8'h60
`define ACCESS_SFR_BANK 4'hf
`define BANK_ACCESS_LOW 4'h0
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 12'h000
`endif

// *** logic/rotate_pkg.sv ***
// Types shared by the byte rotate execution block.
`default_nettype none
package rotate_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } phase_type;
endpackage
`default_nettype wire

// *** logic/bank_resolve.sv ***
// Maps an 8-bit file address to a 12-bit data address.
`timescale 1ns/1ns
`default_nettype none
`include "rotate_defs.svh"
module bank_resolve (
    input wire logic [7:0] faddr_i,
    input wire logic access_i,
    input wire logic [3:0] bank_select_register_i,
    output logic [11:0] addr_o
);
    // Access-bank addresses below 0x60 land in bank 0, those from 0x60 up in the special bank.
    always_comb begin
        if (access_i) begin
            addr_o = {bank_select_register_i, faddr_i};
        end else if (faddr_i < `ACCESS_SPLIT) begin
            addr_o = {`BANK_ACCESS_LOW, faddr_i};
        end else begin
            addr_o = {`ACCESS_SFR_BANK, faddr_i};
        end
    end
endmodule
`default_nettype wire

// *** bench/mem_model.sv ***
// Behavioural data memory on the far side of the byte rotate block.
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:4095];
    logic rd_r = 1'b0;
    // Outside the read window the bus shows the inverted byte, so stale data never passes.
    assign rdata_o = (rd_i | rd_r) ? mem[addr_i] : ~mem[addr_i];
    always @(posedge clk_i) begin
        rd_r <= rd_i;
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// *** bench/test_byte_rotate.sv ***
// Self-checking bench for the byte rotate block.
`timescale 1ns/1ns
`default_nettype none
module test_byte_rotate;
    logic clk_i, rst_b_i, instr_valid_i, carry_i;
    logic [15:0] instr_i;
    logic [3:0] bank_select_register_i;
    logic [7:0] mem_rdata_i, mem_wdata_o, w_data_o;
    logic [11:0] mem_addr_o;
    logic busy_o, mem_rd_o, mem_wr_o, w_wr_o, carry_wr_o, carry_o, neg_o, zero_o, done_o;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    byte_rotate DUT (.clk_i, .rst_b_i, .instr_valid_i, .instr_i, .bank_select_register_i,
        .carry_i, .mem_rdata_i, .busy_o, .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o,
        .w_wr_o, .w_data_o, .carry_wr_o, .carry_o, .neg_o, .zero_o, .done_o);
    mem_model mem (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // Issues one instruction and returns at the falling edge where done shows.
    task automatic issue(input logic [15:0] ins, input logic [3:0] bank, input logic c);
        int k;
        @(negedge clk_i);
        instr_i = ins;
        bank_select_register_i = bank;
        carry_i = c;
        instr_valid_i = 1'b1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        chk({10'h0, busy_o, mem_rd_o}, 12'h003);
        k = 0;
        while (done_o !== 1'b1 && k < 8) begin
            @(negedge clk_i);
            k++;
        end
        chk(12'(k), 12'h002);
        chk({11'h0, busy_o}, 12'h000);
    endtask
    task automatic s_left_w;
        mem.mem[12'h020] = 8'h96;
        issue(16'h4420, 4'h5, 1'b0);
        chk({4'h0, w_data_o}, 12'h02d);
        chk({9'h0, w_wr_o, mem_wr_o, carry_wr_o}, 12'h004);
        chk(mem_addr_o, 12'h020);
    endtask
    task automatic s_left_f;
        mem.mem[12'h533] = 8'h81;
        issue(16'h4733, 4'h5, 1'b0);
        chk({10'h0, w_wr_o, mem_wr_o}, 12'h001);
        chk(mem_addr_o, 12'h533);
        @(negedge clk_i);
        chk({4'h0, mem.mem[12'h533]}, 12'h003);
    endtask
    task automatic s_right_f;
        mem.mem[12'hf80] = 8'h41;
        issue(16'h3280, 4'h3, 1'b1);
        chk(mem_addr_o, 12'hf80);
        chk({4'h0, mem_wdata_o}, 12'h0a0);
        chk({9'h0, carry_wr_o, carry_o, neg_o}, 12'h007);
    endtask
    task automatic s_right_w;
        mem.mem[12'h210] = 8'h01;
        issue(16'h3110, 4'h2, 1'b0);
        chk(mem_addr_o, 12'h210);
        chk({4'h0, w_data_o}, 12'h000);
        chk({9'h0, carry_o, zero_o, mem_wr_o}, 12'h006);
    endtask
    // An opcode that is neither rotate, held valid, must never start the block.
    task automatic s_ignore;
        @(negedge clk_i);
        instr_i = 16'h2420;
        instr_valid_i = 1'b1;
        repeat (4) @(negedge clk_i);
        instr_valid_i = 1'b0;
        chk({10'h0, busy_o, done_o}, 12'h000);
    endtask
    // Reset in mid-instruction must drop every strobe at once.
    task automatic s_reset_mid;
        @(negedge clk_i);
        instr_i = 16'h4420;
        instr_valid_i = 1'b1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        rst_b_i = 1'b0;
        #1;
        chk({9'h0, busy_o, mem_rd_o, done_o}, 12'h000);
        @(negedge clk_i);
        rst_b_i = 1'b1;
    endtask
    initial begin
        rst_b_i = 1'b0;
        instr_valid_i = 1'b0;
        instr_i = 16'h0000;
        bank_select_register_i = 4'h0;
        carry_i = 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        s_left_w();
        s_left_f();
        s_right_f();
        s_right_w();
        s_ignore();
        s_reset_mid();
        s_left_w();
        close_out();
    end
endmodule
`default_nettype wire
